/* File: verilog/mcs_params.svh */
// Offsets, field positions, reset values and timing for the monitor
// conversion sequencer. Definitions only; included by bare name.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCS_OFS_STAT1     8'h00
`define MCS_OFS_LSB_A     8'h03
`define MCS_OFS_LSB_B     8'h05
`define MCS_OFS_SUP_MSB   8'h06
`define MCS_OFS_INT_MSB   8'h07
`define MCS_OFS_EXT_MSB   8'h08
`define MCS_OFS_STAT2     8'h10
`define MCS_OFS_SETUP1    8'h18
`define MCS_OFS_SETUP2    8'h19
`define MCS_OFS_LIM_BASE  8'h40
`define MCS_OFS_MASK1     8'h48
`define MCS_OFS_MASK2     8'h49

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCS_EN_BIT        0
`define MCS_POL_BIT       6
`define MCS_MODE_BIT      4
`define MCS_AVG_OFF_BIT   5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MCS_SETUP1_RST    8'h00
`define MCS_SETUP2_RST    8'h00
`define MCS_MASK_RST      8'h00
// Limits, entry 0 in low byte: int hi/lo, ext hi/lo, supply hi/lo
`define MCS_LIM_RST       48'h00FF_807F_807F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCS_CLK_NS        10
`define MCS_INT_MEAS_NS   712000
`define MCS_EXT_MEAS_NS   1510000
`define MCS_SUP_MEAS_NS   712000
`define MCS_INT_MEAS_CYC  (`MCS_INT_MEAS_NS / `MCS_CLK_NS)
`define MCS_EXT_MEAS_CYC  (`MCS_EXT_MEAS_NS / `MCS_CLK_NS)
`define MCS_SUP_MEAS_CYC  (`MCS_SUP_MEAS_NS / `MCS_CLK_NS)
`define MCS_AVG_LAST      4'hF

`endif

/* File: verilog/mcs_pkg.sv */
// Types of the monitor conversion sequencer.
// Constants live in mcs_params.svh.
package mcs_pkg;

	typedef enum logic [3:0] {
		ST_OFF   = 4'b0001,
		ST_HOLD  = 4'b0010,
		ST_START = 4'b0100,
		ST_WAIT  = 4'b1000
	} mcs_state_t;

	typedef enum logic [1:0] {
		CH_SUP = 2'h0,
		CH_INT = 2'h1,
		CH_EXT = 2'h2
	} mcs_chan_t;

endpackage : mcs_pkg

/* File: verilog/mcs_sequencer.sv */
// Conversion sequencer for a three-channel monitoring ADC: supply,
// internal and external temperature, with limits and result registers.
// Assumes the serial front end and ADC digital side share sys_clk_i.

`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_sequencer
	import mcs_pkg::*;
#(
	parameter int INT_MEAS_CYC = `MCS_INT_MEAS_CYC,
	parameter int EXT_MEAS_CYC = `MCS_EXT_MEAS_CYC,
	parameter int SUP_MEAS_CYC = `MCS_SUP_MEAS_CYC
) (
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic       serial_busy_i,
	input  wire logic [9:0] adc_data_i,
	output logic      [7:0] reg_rdata_o,
	output logic            adc_start_o,
	output logic            adc_rst_o,
	output logic      [1:0] adc_chan_o,
	output logic            ref_amp_en_o,
	output logic            int_o
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0] setup1;
	logic [7:0] setup2;
	logic [7:0] mask1;
	logic [7:0] mask2;
	logic [7:0] lim [6];

	wire wr_setup1 = reg_wr_i && (reg_addr_i == `MCS_OFS_SETUP1);
	wire wr_setup2 = reg_wr_i && (reg_addr_i == `MCS_OFS_SETUP2);
	wire wr_mask1  = reg_wr_i && (reg_addr_i == `MCS_OFS_MASK1);
	wire wr_mask2  = reg_wr_i && (reg_addr_i == `MCS_OFS_MASK2);

	wire mon_en     = setup1[`MCS_EN_BIT];
	wire pol_high   = setup1[`MCS_POL_BIT];
	wire single     = setup2[`MCS_MODE_BIT];
	wire avg_off    = setup2[`MCS_AVG_OFF_BIT];

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			setup1 <= `MCS_SETUP1_RST;
			setup2 <= `MCS_SETUP2_RST;
			mask1  <= `MCS_MASK_RST;
			mask2  <= `MCS_MASK_RST;
		end else begin
			if (wr_setup1) setup1 <= reg_wdata_i;
			if (wr_setup2) setup2 <= reg_wdata_i;
			if (wr_mask1)  mask1  <= reg_wdata_i;
			if (wr_mask2)  mask2  <= reg_wdata_i;
		end
	end

	localparam logic [47:0] LIM_RST = `MCS_LIM_RST;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_lim
			wire wr_lim = reg_wr_i &&
				(reg_addr_i == `MCS_OFS_LIM_BASE + 8'(gi));
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i)
					lim[gi] <= LIM_RST[gi*8 +: 8];
				else if (wr_lim)
					lim[gi] <= reg_wdata_i;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Channel choice
	// ----------------------------------------------------------------
	// Select code 00 supply, 01 internal, 10 external; 11 is reserved
	// and falls back to supply so the sequencer never stalls.
	mcs_chan_t sel_chan;
	always_comb begin
		case (setup2[1:0])
			2'h1:    sel_chan = CH_INT;
			2'h2:    sel_chan = CH_EXT;
			default: sel_chan = CH_SUP;
		endcase
	end

	mcs_chan_t cur_chan;
	mcs_chan_t rr_next;
	always_comb begin
		case (cur_chan)
			CH_SUP:  rr_next = CH_INT;
			CH_INT:  rr_next = CH_EXT;
			default: rr_next = CH_SUP;
		endcase
	end

	mcs_chan_t start_chan;
	assign start_chan = single ? sel_chan : cur_chan;

	logic [17:0] meas_len;
	always_comb begin
		case (cur_chan)
			CH_INT:  meas_len = 18'(INT_MEAS_CYC - 1);
			CH_EXT:  meas_len = 18'(EXT_MEAS_CYC - 1);
			default: meas_len = 18'(SUP_MEAS_CYC - 1);
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	mcs_state_t  state;
	mcs_state_t  next_state;
	logic [17:0] timer;
	logic [3:0]  avg_cnt;
	logic [13:0] acc;

	wire meas_done = (state == ST_WAIT) && (timer == 18'h0);
	wire avg_on    = single && !avg_off && (cur_chan != CH_SUP);
	wire avg_last  = (avg_cnt == `MCS_AVG_LAST);
	wire commit    = meas_done && (!avg_on || avg_last);
	mcs_chan_t   next_chan;
	assign next_chan = (commit && !single) ? rr_next : start_chan;

	always_comb begin
		next_state = state;
		case (state)
			ST_OFF:   if (mon_en) next_state = ST_START;
			ST_HOLD:  if (!serial_busy_i)
				next_state = mon_en ? ST_START : ST_OFF;
			ST_START: next_state = ST_WAIT;
			ST_WAIT:  if (meas_done) next_state = ST_START;
			default:  next_state = ST_OFF;
		endcase
		if (!mon_en)
			next_state = ST_OFF;
		else if (serial_busy_i)
			next_state = ST_HOLD;
	end

	wire [13:0] acc_sum = acc + {{4{adc_data_i[9]}}, adc_data_i};
	wire [9:0]  new_val = avg_on ? acc_sum[13:4] : adc_data_i;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state    <= ST_OFF;
			cur_chan <= CH_SUP;
			timer    <= 18'h0;
		end else begin
			state <= next_state;
			if (state == ST_START)
				timer <= meas_len;
			else if (state == ST_WAIT && timer != 18'h0)
				timer <= timer - 18'h1;
			// Set on entry so adc_chan_o is right during the start pulse
			if (next_state == ST_START)
				cur_chan <= next_chan;
		end
	end

	// Partial averages are dropped on abort so a result never mixes
	// samples from before and after a serial access.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || state == ST_HOLD || state == ST_OFF) begin
			avg_cnt <= 4'h0;
			acc     <= 14'h0;
		end else if (meas_done && next_state == ST_START) begin
			avg_cnt <= commit ? 4'h0 : avg_cnt + 4'h1;
			acc     <= commit ? 14'h0 : acc_sum;
		end
	end

	assign adc_start_o  = (state == ST_START);
	assign adc_rst_o    = (state == ST_HOLD);
	assign adc_chan_o   = cur_chan;
	assign ref_amp_en_o = mon_en;

	// ----------------------------------------------------------------
	// Results and limit checks
	// ----------------------------------------------------------------
	// A commit is only taken if the abort did not strike that cycle.
	wire take = commit && !serial_busy_i && mon_en;

	logic [9:0] res_sup;
	logic [9:0] res_int;
	logic [9:0] res_ext;
	logic [7:0] msb_sup;
	logic [7:0] msb_int;
	logic [7:0] msb_ext;
	logic       lock_a;
	logic       lock_b;

	wire is_int = (cur_chan == CH_INT);
	wire is_ext = (cur_chan == CH_EXT);
	wire is_sup = (cur_chan == CH_SUP);

	// Temperatures: quarter-degree twos complement, compared in degrees
	wire signed [7:0] t_deg = $signed(new_val[9:2]);
	wire [7:0] t_hi = is_int ? lim[0] : lim[2];
	wire [7:0] t_lo = is_int ? lim[1] : lim[3];
	wire t_above = t_deg >  $signed(t_hi);
	wire t_below = t_deg <= $signed(t_lo);
	// Supply: unsigned code, top eight bits against the byte limit
	wire s_above = new_val[9:2] >  lim[4];
	wire s_below = new_val[9:2] <= lim[5];

	wire rd_lsb_a = reg_rd_i && (reg_addr_i == `MCS_OFS_LSB_A);
	wire rd_lsb_b = reg_rd_i && (reg_addr_i == `MCS_OFS_LSB_B);
	wire rd_msb_a = reg_rd_i && (reg_addr_i == `MCS_OFS_SUP_MSB ||
		reg_addr_i == `MCS_OFS_INT_MSB);
	wire rd_msb_b = reg_rd_i && (reg_addr_i == `MCS_OFS_EXT_MSB);
	wire rd_stat1 = reg_rd_i && (reg_addr_i == `MCS_OFS_STAT1);
	wire rd_stat2 = reg_rd_i && (reg_addr_i == `MCS_OFS_STAT2);

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			res_sup <= 10'h000;
			res_int <= 10'h000;
			res_ext <= 10'h000;
			msb_sup <= 8'h00;
			msb_int <= 8'h00;
			msb_ext <= 8'h00;
		end else if (take) begin
			if (is_sup) res_sup <= new_val;
			if (is_int) res_int <= new_val;
			if (is_ext) res_ext <= new_val;
			if (is_sup && !lock_a) msb_sup <= new_val[9:2];
			if (is_int && !lock_a) msb_int <= new_val[9:2];
			if (is_ext && !lock_b) msb_ext <= new_val[9:2];
		end
	end

	// Lock only when the low byte is read first; an MSB read unlocks
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			lock_a <= 1'b0;
			lock_b <= 1'b0;
		end else begin
			if (rd_msb_a)      lock_a <= 1'b0;
			else if (rd_lsb_a) lock_a <= 1'b1;
			if (rd_msb_b)      lock_b <= 1'b0;
			else if (rd_lsb_b) lock_b <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Alarm flags
	// ----------------------------------------------------------------
	logic [7:0] stat1;
	logic [7:0] stat2;

	wire [7:0] set1 = {4'h0,
		take && is_ext && t_below && !mask1[3],
		take && is_ext && t_above && !mask1[2],
		take && is_int && t_below && !mask1[1],
		take && is_int && t_above && !mask1[0]};
	wire [7:0] set2 = {6'h00,
		take && is_sup && s_below && !mask2[1],
		take && is_sup && s_above && !mask2[0]};

	// Clear on read; a new alarm in the read cycle survives the clear
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			stat1 <= 8'h00;
			stat2 <= 8'h00;
		end else begin
			stat1 <= (rd_stat1 ? 8'h00 : stat1) | set1;
			stat2 <= (rd_stat2 ? 8'h00 : stat2) | set2;
		end
	end

	wire any_alarm = (stat1 != 8'h00) || (stat2 != 8'h00);
	assign int_o = pol_high ? any_alarm : !any_alarm;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			`MCS_OFS_STAT1:          rd_mux = stat1;
			`MCS_OFS_STAT2:          rd_mux = stat2;
			`MCS_OFS_LSB_A:          rd_mux = {4'h0, res_int[1:0], res_sup[1:0]};
			`MCS_OFS_LSB_B:          rd_mux = {6'h00, res_ext[1:0]};
			`MCS_OFS_SUP_MSB:        rd_mux = msb_sup;
			`MCS_OFS_INT_MSB:        rd_mux = msb_int;
			`MCS_OFS_EXT_MSB:        rd_mux = msb_ext;
			`MCS_OFS_SETUP1:         rd_mux = setup1;
			`MCS_OFS_SETUP2:         rd_mux = setup2;
			`MCS_OFS_MASK1:          rd_mux = mask1;
			`MCS_OFS_MASK2:          rd_mux = mask2;
			`MCS_OFS_LIM_BASE:       rd_mux = lim[0];
			`MCS_OFS_LIM_BASE + 8'h1: rd_mux = lim[1];
			`MCS_OFS_LIM_BASE + 8'h2: rd_mux = lim[2];
			`MCS_OFS_LIM_BASE + 8'h3: rd_mux = lim[3];
			`MCS_OFS_LIM_BASE + 8'h4: rd_mux = lim[4];
			`MCS_OFS_LIM_BASE + 8'h5: rd_mux = lim[5];
			default:                 rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux;
	end

endmodule : mcs_sequencer

/* File: test/mcs_seq_monitor.sv */
// Port checker for the monitor conversion sequencer.
// Bound into mcs_sequencer; sees only its ports.
`timescale 1ns/1ps
module mcs_seq_monitor #(
	parameter int SUP_MEAS_CYC = 6
) (
	input wire logic       sys_clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic       serial_busy_i,
	input wire logic [9:0] adc_data_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       adc_start_o,
	input wire logic       adc_rst_o,
	input wire logic [1:0] adc_chan_o,
	input wire logic       ref_amp_en_o,
	input wire logic       int_o
);
	logic       mode;
	logic [1:0] sel;
	logic [1:0] last_ch;
	logic       abt;
	logic [7:0] gap;
	wire  [1:0] rr_ch = (last_ch == 2'h2) ? 2'h0 : last_ch + 2'h1;
	wire  [1:0] sg_ch = (sel == 2'h3) ? 2'h0 : sel;
	wire        wr_s2 = reg_wr_i && (reg_addr_i == 8'h19);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode <= 1'b0;
			sel  <= 2'h0;
		end else if (wr_s2) begin
			mode <= reg_wdata_i[4];
			sel  <= reg_wdata_i[1:0];
		end
	end
	// Aborted or idle runs restart on the old channel in round robin mode, on the selected one in single mode, with a short gap
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i)
			abt <= 1'b1;
		else if (adc_start_o)
			abt <= 1'b0;
		else if (adc_rst_o || !ref_amp_en_o)
			abt <= 1'b1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i)
			gap <= 8'hFF;
		else if (adc_start_o)
			gap <= 8'h00;
		else if (gap != 8'hFF)
			gap <= gap + 8'h01;
	end
	always_ff @(posedge sys_clk_i) begin
		if (adc_start_o)
			last_ch <= adc_chan_o;
	end

	rr_order_a: assert property (adc_start_o && !abt && !mode |-> adc_chan_o == rr_ch)
		else $error("round robin order broken");
	single_chan_a: assert property (adc_start_o && mode |-> adc_chan_o == sg_ch)
		else $error("single mode converts wrong channel");
	busy_abort_a: assert property (serial_busy_i && ref_amp_en_o |=> adc_rst_o)
		else $error("serial access did not hold the converter");
	restart_soon_a: assert property ($fell(adc_rst_o) && ref_amp_en_o |-> ##[0:2] adc_start_o)
		else $error("no restart after serial access");
	held_no_start_a: assert property (adc_rst_o |-> !adc_start_o)
		else $error("start while converter held");
	start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
		else $error("start longer than one cycle");
	off_idle_a: assert property (!ref_amp_en_o && $past(!ref_amp_en_o) |-> !adc_start_o)
		else $error("conversion while monitoring off");
	amp_follow_a: assert property (reg_wr_i && reg_addr_i == 8'h18
		|=> ref_amp_en_o == $past(reg_wdata_i[0]))
		else $error("amplifier enable not following setup");
	window_min_a: assert property (adc_start_o && !abt |-> gap >= SUP_MEAS_CYC)
		else $error("measurement window too short");
	chan_steady_a: assert property (!$stable(adc_chan_o) |-> adc_start_o)
		else $error("channel changed outside a start");

	rr_ext_c: cover property (adc_start_o && !mode && adc_chan_o == 2'h2);
	single_c: cover property (adc_start_o && mode && adc_chan_o == 2'h1);
	abort_c: cover property ($fell(adc_rst_o) ##[0:2] adc_start_o);
endmodule : mcs_seq_monitor

bind mcs_sequencer mcs_seq_monitor #(.SUP_MEAS_CYC(SUP_MEAS_CYC)) mon_u (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.serial_busy_i(serial_busy_i), .adc_data_i(adc_data_i), .reg_rdata_o(reg_rdata_o),
	.adc_start_o(adc_start_o), .adc_rst_o(adc_rst_o), .adc_chan_o(adc_chan_o),
	.ref_amp_en_o(ref_amp_en_o), .int_o(int_o));

/* File: test/mcs_adc_model.sv */
// Behavioural converter front end feeding the sequencer.
// Codes per channel come from the bench; optional +/-1 dither.
`timescale 1ns/1ps
module mcs_adc_model (
	input  wire logic       sys_clk_i,
	input  wire logic       adc_start_i,
	input  wire logic       adc_rst_i,
	input  wire logic [1:0] adc_chan_i,
	input  wire logic       dith_i,
	input  wire logic [9:0] code_sup_i,
	input  wire logic [9:0] code_int_i,
	input  wire logic [9:0] code_ext_i,
	output logic      [9:0] adc_data_o
);
	logic       odd = 1'b0;
	wire  [9:0] base = (adc_chan_i == 2'h0) ? code_sup_i :
		(adc_chan_i == 2'h1) ? code_int_i : code_ext_i;
	// Dither cancels only over an even number of windows
	always_ff @(posedge sys_clk_i) begin
		if (adc_start_i)
			odd <= !odd;
	end
	// Held converter gives garbage, never the last code
	assign adc_data_o = adc_rst_i ? ~base : !dith_i ? base :
		odd ? base + 10'h001 : base - 10'h001;
endmodule : mcs_adc_model

/* File: test/test_monitor_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer.
// Bench acts as serial host; converter modelled by mcs_adc_model.
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin errors++; \
	$display("unexpected at %0t: %s", $time, m); end end
module test_monitor_conversion_sequencer;
	localparam int EXT = 12;
	logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, busy = 0, dith = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, d;
	logic [9:0] c_sup = 10'h2DD, c_int = 10'h066, c_ext = 10'h3A0, adc_d;
	logic st, arst, amp, irq;
	logic [1:0] ch;
	int errors = 0, n_checks = 0, st_cnt = 0, cyc = 0, t0, exp_ch[4] = '{0, 1, 2, 0};

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (st) st_cnt++;
	end

	mcs_sequencer #(.INT_MEAS_CYC(8), .EXT_MEAS_CYC(EXT), .SUP_MEAS_CYC(6)) dut_u (
		.sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .serial_busy_i(busy), .adc_data_i(adc_d),
		.reg_rdata_o(rdata), .adc_start_o(st), .adc_rst_o(arst), .adc_chan_o(ch),
		.ref_amp_en_o(amp), .int_o(irq));
	mcs_adc_model adc_u (.sys_clk_i(clk), .adc_start_i(st), .adc_rst_i(arst),
		.adc_chan_i(ch), .dith_i(dith), .code_sup_i(c_sup), .code_int_i(c_int),
		.code_ext_i(c_ext), .adc_data_o(adc_d));

	// Serial transaction: busy wraps the strobe, as on the real front end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk) busy = 1;
		addr = a;
		wd = v;
		wr_s = 1;
		@(negedge clk) wr_s = 0;
		@(negedge clk) busy = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk) busy = 1;
		addr = a;
		rd_s = 1;
		@(negedge clk) rd_s = 0;
		v = rdata;
		@(negedge clk) busy = 0;
	endtask : rd
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		rd(a, d);
		`CHK(d, e, "register read")
	endtask : chk_rd
	task automatic wait_st();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (st !== 1'b1 && n < 400);
		if (n >= 400) `CHK(1'b0, 1'b1, "no conversion start")
		t0 = cyc;
	endtask : wait_st
	task automatic ws(input logic [1:0] e);
		wait_st();
		`CHK(ch, e, "start channel")
	endtask : ws
	task automatic wait_ch(input logic [1:0] e);
		do wait_st(); while (ch !== e && errors == 0);
	endtask : wait_ch
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		int t1;
		repeat (2) @(negedge clk);
		rst = 0;
		chk_rd(8'h18, 8'h00);
		chk_rd(8'h19, 8'h00);
		repeat (20) @(negedge clk);
		`CHK(st_cnt, 0, "start while disabled")
		`CHK(amp, 1'b0, "amplifier on at reset")
		$display("reset test done");
		wr(8'h18, 8'h01);
		`CHK(amp, 1'b1, "amplifier off")
		ws(2'h0);
		ws(2'h1);
		ws(2'h2);
		ws(2'h0);
		chk_rd(8'h06, 8'hB7);
		chk_rd(8'h07, 8'h19);
		chk_rd(8'h08, 8'hE8);
		chk_rd(8'h03, 8'h09);
		c_sup = 10'h100;
		wait_ch(2'h0);
		wait_ch(2'h1);
		chk_rd(8'h06, 8'hB7);
		wait_ch(2'h0);
		wait_ch(2'h1);
		chk_rd(8'h06, 8'h40);
		$display("round robin test done");
		wr(8'h40, 8'h10);
		wait_ch(2'h1);
		wait_ch(2'h2);
		`CHK(irq, 1'b0, "active-low alarm")
		wr(8'h18, 8'h41);
		`CHK(irq, 1'b1, "active-high alarm")
		chk_rd(8'h00, 8'h01);
		`CHK(irq, 1'b0, "alarm not cleared")
		wr(8'h48, 8'h01);
		wr(8'h43, 8'hE8);
		wr(8'h44, 8'h3F);
		wait_ch(2'h1);
		wait_ch(2'h2);
		wait_ch(2'h0);
		wait_ch(2'h1);
		chk_rd(8'h00, 8'h08);
		chk_rd(8'h10, 8'h01);
		$display("limit test done");
		wait_ch(2'h2);
		@(negedge clk) busy = 1;
		@(negedge clk) `CHK(arst, 1'b1, "no abort")
		busy = 0;
		@(negedge clk) `CHK(arst, 1'b0, "held too long")
		`CHK(st, 1'b1, "no restart")
		`CHK(ch, 2'h2, "restart channel")
		$display("abort test done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h30 | 8'(i), 8'h30 | 8'(i));
			wr(8'h19, 8'h30 | 8'(i));
			wait_st();
			ws(2'(exp_ch[i]));
			t1 = t0;
			ws(2'(exp_ch[i]));
			if (i == 2)
				`CHK((t0 - t1 == EXT + 1) || (t0 - t1 == EXT + 2), 1'b1, "ext window")
		end
		c_int = 10'h0A0;
		dith = 1;
		wr(8'h19, 8'h11);
		repeat (17) ws(2'h1);
		chk_rd(8'h07, 8'h28);
		chk_rd(8'h03, 8'h00);
		wr(8'h19, 8'h31);
		repeat (3) ws(2'h1);
		rd(8'h03, d);
		`CHK(d[3:2] !== 2'b00, 1'b1, "averaging not off")
		$display("single channel test done");
		wr(8'h18, 8'h00);
		`CHK(amp, 1'b0, "amplifier stays on")
		t1 = st_cnt;
		repeat (40) @(negedge clk);
		`CHK(st_cnt, t1, "start after disable")
		$display("disable test done");
		end_of_test();
	end
endmodule : test_monitor_conversion_sequencer
